// ==== rtl/anreg_pkg.sv ====
// constants for the negotiation status and datapath config registers
package anreg_pkg;

  // bus geometry
  localparam int ANREG_ADDR_W = 8;
  localparam int ANREG_DATA_W = 32;
  localparam int ANREG_IDX_W = 6;
  typedef logic [ANREG_IDX_W-1:0] anreg_idx_t;
  typedef logic [15:0] anreg_word_t;

  // register indices, byte address is four times the index
  localparam anreg_idx_t IDX_LP_ABILITY = 6'h05;
  localparam anreg_idx_t IDX_EXPANSION = 6'h06;
  localparam anreg_idx_t IDX_CONFIG = 6'h10;
  localparam anreg_idx_t IDX_IRQ_STATUS = 6'h20;
  localparam anreg_idx_t IDX_IRQ_MASK = 6'h21;

  // link partner ability fields
  localparam int LP_SEL_LSB = 0;
  localparam int LP_SEL_MSB = 4;
  localparam int LP_ABIL_LSB = 5;
  localparam int LP_ABIL_MSB = 8;
  localparam logic [8:0] LP_RESET = 9'h000;

  // expansion register fields
  localparam int EXP_AN_ABLE = 0;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_LOCAL_NP = 2;
  localparam int EXP_PARTNER_NP = 3;
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_RSVD_LSB = 5;

  // datapath config fields
  localparam int CFG_TX_MODE = 10;
  localparam int CFG_REPEATER = 11;
  localparam int CFG_FORCE_SD = 12;
  localparam int CFG_BYP_ALIGN = 13;
  localparam int CFG_BYP_SCR = 14;
  localparam int CFG_BYP_CODING = 15;
  localparam int CFG_LSB = 10;
  localparam logic [5:0] CFG_RESET = 6'h01;

  // interrupt status and mask fields
  localparam int IRQ_W = 3;
  localparam int IRQ_PAGE_RX = 0;
  localparam int IRQ_PD_FAULT = 1;
  localparam int IRQ_LP_UPDATE = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

endpackage

// ==== rtl/anreg_top.sv ====
// negotiation status and datapath config register bank behind apb
`timescale 1ns/1ps
`default_nettype none
module anreg_top (
  // clock, reset, enable
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [anreg_pkg::ANREG_ADDR_W-1:0] PADDR,
  input wire logic [anreg_pkg::ANREG_DATA_W-1:0] PWDATA,
  output logic [anreg_pkg::ANREG_DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // negotiation engine, same clock
  input wire logic LP_LOAD,
  input wire logic [8:0] LP_ABILITY_IN,
  input wire logic PAGE_RX_PULSE,
  input wire logic PD_FAULT_PULSE,
  input wire logic PARTNER_NP_IN,
  input wire logic PARTNER_AN_IN,
  // strap and analog pins
  input wire logic STRAP_BYPASS_CODING,
  input wire logic STRAP_REPEATER,
  input wire logic SIGNAL_DETECT_PIN,
  // datapath controls
  output logic BYPASS_CODING,
  output logic BYPASS_SCRAMBLE,
  output logic BYPASS_ALIGN,
  output logic FORCE_SD,
  output logic REPEATER_MODE,
  output logic TX_MODE,
  output logic SIGNAL_DETECT_OUT,
  // interrupt
  output logic IRQ
);
  import anreg_pkg::*;

  // state
  logic [8:0] lp_reg, lp_next;
  logic pd_fault_reg, pd_fault_next;
  logic page_rx_reg, page_rx_next;
  logic partner_np_reg;
  logic partner_an_reg;
  logic [5:0] cfg_reg, cfg_next;
  logic strap_done_reg;
  logic [IRQ_W-1:0] status_reg, status_next;
  logic [IRQ_W-1:0] mask_reg, mask_next;
  logic irq_reg;
  logic [ANREG_DATA_W-1:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic sd_out_reg;
  // pin synchronisers, no reset so they flush during reset
  logic [2:0] pin_s1, pin_s2;

  // address decode
  wire anreg_idx_t idx = PADDR[ANREG_ADDR_W-1:2];
  wire logic setup = PSEL & ~PENABLE;
  wire logic done = PSEL & PENABLE & pready_reg;
  wire logic hit_lp = (idx == IDX_LP_ABILITY);
  wire logic hit_exp = (idx == IDX_EXPANSION);
  wire logic hit_cfg = (idx == IDX_CONFIG);
  wire logic hit_st = (idx == IDX_IRQ_STATUS);
  wire logic hit_mask = (idx == IDX_IRQ_MASK);
  wire logic mapped = hit_lp | hit_exp | hit_cfg | hit_st | hit_mask;
  wire logic wr_done = done & PWRITE & mapped;
  wire logic rd_done = done & ~PWRITE;
  wire logic exp_rd = rd_done & hit_exp;
  wire logic st_rd = rd_done & hit_st;

  // read data is taken at the setup edge and flags clear at the
  // completion edge, so a flag event landing on that setup edge is
  // cleared unseen; the negotiation engine must space its pulses
  // read views, reserved bits zero
  wire anreg_word_t lp_view = {7'h00, lp_reg};
  wire anreg_word_t exp_view = {11'h000, pd_fault_reg, partner_np_reg,
    1'b0, page_rx_reg, partner_an_reg};
  wire anreg_word_t cfg_view = {cfg_reg, 10'h000};
  wire anreg_word_t st_view = {13'h0000, status_reg};
  wire anreg_word_t mask_view = {13'h0000, mask_reg};
  wire anreg_word_t rd_mux = hit_lp ? lp_view :
    hit_exp ? exp_view :
    hit_cfg ? cfg_view :
    hit_st ? st_view :
    hit_mask ? mask_view : 16'h0000;

  // partner ability loads only from negotiation logic
  assign lp_next = LP_LOAD ? LP_ABILITY_IN : lp_reg;

  // latched-high flags, a new event beats the read clear
  assign pd_fault_next = PD_FAULT_PULSE | (pd_fault_reg & ~exp_rd);
  assign page_rx_next = PAGE_RX_PULSE | (page_rx_reg & ~exp_rd);

  // the straps are caught one edge after reset release, not during
  // reset, so both synchroniser stages have settled; a config write in
  // that very first cycle loses to the strap capture
  // writable config, straps caught on first enabled edge after reset
  wire logic [5:0] cfg_wr = wr_done & hit_cfg ?
    PWDATA[CFG_BYP_CODING:CFG_LSB] : cfg_reg;
  assign cfg_next = strap_done_reg ? cfg_wr :
    {pin_s2[0], cfg_reg[4:2], pin_s2[1], cfg_reg[0]};

  // an event in the cycle of the status read survives the clear,
  // but an event landing on the setup edge of the read is cleared unseen
  // interrupt status, set beats the clear on read
  wire logic [IRQ_W-1:0] events = {LP_LOAD, PD_FAULT_PULSE, PAGE_RX_PULSE};
  assign status_next = events | (st_rd ? IRQ_RESET : status_reg);
  assign mask_next = wr_done & hit_mask ? PWDATA[IRQ_W-1:0] : mask_reg;

  // no reset here: reset is held long enough for both stages to flush
  // pin synchronisers: coding strap, repeater strap, signal detect
  always_ff @(posedge MCLK) begin
    if (CE) begin
      pin_s1 <= {SIGNAL_DETECT_PIN, STRAP_REPEATER, STRAP_BYPASS_CODING};
      pin_s2 <= pin_s1;
    end
  end

  // negotiation status registers
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      lp_reg <= LP_RESET;
      pd_fault_reg <= 1'b0;
      page_rx_reg <= 1'b0;
      partner_np_reg <= 1'b0;
      partner_an_reg <= 1'b0;
    end else if (CE) begin
      lp_reg <= lp_next;
      pd_fault_reg <= pd_fault_next;
      page_rx_reg <= page_rx_next;
      partner_np_reg <= PARTNER_NP_IN;
      partner_an_reg <= PARTNER_AN_IN;
    end
  end

  // config, interrupt state and signal detect
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      cfg_reg <= CFG_RESET;
      strap_done_reg <= 1'b0;
      status_reg <= IRQ_RESET;
      mask_reg <= IRQ_RESET;
      irq_reg <= 1'b0;
      sd_out_reg <= 1'b0;
    end else if (CE) begin
      cfg_reg <= cfg_next;
      strap_done_reg <= 1'b1;
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= |(status_reg & mask_reg);
      sd_out_reg <= pin_s2[2] | cfg_reg[CFG_FORCE_SD-CFG_LSB];
    end
  end

  // pready answers every setup one cycle later, so no wait states;
  // pslverr marks an index that no register decodes
  // apb answer, one wait-free access phase
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (CE) begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
      if (setup & ~PWRITE) begin
        prdata_reg <= {16'h0000, rd_mux};
      end
    end
  end

  // outputs straight from flops
  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign BYPASS_CODING = cfg_reg[CFG_BYP_CODING-CFG_LSB];
  assign BYPASS_SCRAMBLE = cfg_reg[CFG_BYP_SCR-CFG_LSB];
  assign BYPASS_ALIGN = cfg_reg[CFG_BYP_ALIGN-CFG_LSB];
  assign FORCE_SD = cfg_reg[CFG_FORCE_SD-CFG_LSB];
  assign REPEATER_MODE = cfg_reg[CFG_REPEATER-CFG_LSB];
  assign TX_MODE = cfg_reg[CFG_TX_MODE-CFG_LSB];
  assign SIGNAL_DETECT_OUT = sd_out_reg;
  assign IRQ = irq_reg;

  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  // partner ability follows a load
  lp_load_a: assert property (CE && LP_LOAD |=>
    lp_reg[LP_ABIL_MSB:LP_ABIL_LSB] == $past(LP_ABILITY_IN[8:5]))
    else $error("partner ability bits not loaded");
  lp_sel_a: assert property (CE && LP_LOAD |=>
    lp_reg[LP_SEL_MSB:LP_SEL_LSB] == $past(LP_ABILITY_IN[4:0]))
    else $error("partner selector not loaded");
  lp_hold_a: assert property (CE && !LP_LOAD |=> $stable(lp_reg))
    else $error("partner ability changed without a load");

  // expansion read data
  exp_rsvd_a: assert property (CE && setup && !PWRITE && hit_exp |=>
    PRDATA[31:EXP_RSVD_LSB] == 27'h0000000)
    else $error("reserved expansion bits not zero");
  local_np_a: assert property (CE && setup && !PWRITE && hit_exp |=>
    !PRDATA[EXP_LOCAL_NP])
    else $error("local next page bit read as one");
  partner_np_a: assert property (CE ##1 CE && setup && !PWRITE
    && hit_exp |=> PRDATA[EXP_PARTNER_NP] == $past(PARTNER_NP_IN, 2))
    else $error("partner next page not reported");
  an_able_a: assert property (CE ##1 CE && setup && !PWRITE
    && hit_exp |=> PRDATA[EXP_AN_ABLE] == $past(PARTNER_AN_IN, 2))
    else $error("partner negotiation capable not reported");

  // latched-high flags
  pd_fault_a: assert property (CE && PD_FAULT_PULSE |=> pd_fault_reg)
    else $error("parallel fault not latched");
  page_set_a: assert property (CE && PAGE_RX_PULSE |=> page_rx_reg)
    else $error("page received not latched");
  page_hold_a: assert property (CE && page_rx_reg && !exp_rd
    |=> page_rx_reg)
    else $error("page received dropped without a read");
  page_clr_a: assert property (CE && exp_rd && !PAGE_RX_PULSE
    |=> !page_rx_reg)
    else $error("page received not cleared by read");

  // config register
  strap_a: assert property (CE && !strap_done_reg |=>
    BYPASS_CODING == $past(pin_s2[0]))
    else $error("coding strap not captured");
  strap_rep_a: assert property (CE && !strap_done_reg |=>
    REPEATER_MODE == $past(pin_s2[1]))
    else $error("repeater strap not captured");
  cfg_write_a: assert property (CE && strap_done_reg && wr_done && hit_cfg
    |=> {BYPASS_SCRAMBLE, BYPASS_ALIGN, FORCE_SD, TX_MODE} ==
    {$past(PWDATA[14]), $past(PWDATA[13]), $past(PWDATA[12]),
    $past(PWDATA[10])})
    else $error("config write not applied");
  tx_reset_a: assert property ($rose(RESET_N) |-> TX_MODE)
    else $error("tx mode not one after reset");
  force_sd_a: assert property (CE && FORCE_SD |=> SIGNAL_DETECT_OUT)
    else $error("signal detect not forced");
  ro_write_a: assert property (CE && wr_done && (hit_exp || hit_lp)
    && !LP_LOAD && !PAGE_RX_PULSE && !PD_FAULT_PULSE |=>
    $stable(lp_reg) && $stable(page_rx_reg) && $stable(pd_fault_reg))
    else $error("read-only register changed by a write");

  // expansion flags and partner levels
  pd_read_a: assert property (CE && setup && !PWRITE && hit_exp |=>
    PRDATA[EXP_PD_FAULT] == $past(pd_fault_reg))
    else $error("parallel fault bit not read back");
  page_read_a: assert property (CE && setup && !PWRITE && hit_exp |=>
    PRDATA[EXP_PAGE_RX] == $past(page_rx_reg))
    else $error("page received bit not read back");
  pd_hold_a: assert property (CE && pd_fault_reg && !exp_rd
    |=> pd_fault_reg)
    else $error("parallel fault dropped without a read");
  pd_clr_a: assert property (CE && exp_rd && !PD_FAULT_PULSE
    |=> !pd_fault_reg)
    else $error("parallel fault not cleared by read");
  np_track_a: assert property (CE |=>
    partner_np_reg == $past(PARTNER_NP_IN))
    else $error("partner next page not tracked");
  an_track_a: assert property (CE |=>
    partner_an_reg == $past(PARTNER_AN_IN))
    else $error("partner negotiation capable not tracked");

  // partner ability read path
  lp_read_a: assert property (CE && setup && !PWRITE && hit_lp |=>
    PRDATA[LP_ABIL_MSB:LP_SEL_LSB] == $past(lp_reg))
    else $error("partner ability not read back");
  lp_rsvd_a: assert property (CE && setup && !PWRITE && hit_lp |=>
    PRDATA[31:LP_ABIL_MSB+1] == 23'h000000)
    else $error("partner ability reserved bits not zero");

  // config read path and write control
  cfg_read_a: assert property (CE && setup && !PWRITE && hit_cfg |=>
    PRDATA[15:CFG_LSB] == $past(cfg_reg))
    else $error("config bits not read back");
  cfg_rsvd_a: assert property (CE && setup && !PWRITE && hit_cfg |=>
    PRDATA[CFG_LSB-1:0] == 10'h000)
    else $error("unimplemented config bits not zero");
  cfg_strap_wr_a: assert property (CE && strap_done_reg && wr_done
    && hit_cfg |=> {BYPASS_CODING, REPEATER_MODE} ==
    {$past(PWDATA[CFG_BYP_CODING]), $past(PWDATA[CFG_REPEATER])})
    else $error("strapped config bits not writable");
  cfg_hold_a: assert property (CE && strap_done_reg
    && !(wr_done && hit_cfg) |=> $stable(cfg_reg))
    else $error("config changed without a write");

  // signal detect path
  sd_pass_a: assert property (CE && pin_s2[2] |=> SIGNAL_DETECT_OUT)
    else $error("signal detect pin not passed through");
  sd_idle_a: assert property (CE && !FORCE_SD && !pin_s2[2]
    |=> !SIGNAL_DETECT_OUT)
    else $error("signal detect active without cause");

  // apb answer timing
  ready_a: assert property (CE && setup |=> PREADY)
    else $error("no ready after setup");
  ready_once_a: assert property (CE && !setup |=> !PREADY)
    else $error("ready without a setup");
  err_map_a: assert property (CE && setup |=> PSLVERR == !$past(mapped))
    else $error("slave error does not match the decode");
  unmapped_rd_a: assert property (CE && setup && !PWRITE && !mapped
    |=> PRDATA == 32'h00000000)
    else $error("unmapped read data not zero");
  rd_hold_a: assert property (CE && !(setup && !PWRITE) |=> $stable(PRDATA))
    else $error("read data changed without a read");

  // interrupt status, mask and level
  st_page_a: assert property (CE && PAGE_RX_PULSE |=>
    status_reg[IRQ_PAGE_RX])
    else $error("page event not in status");
  st_fault_a: assert property (CE && PD_FAULT_PULSE |=>
    status_reg[IRQ_PD_FAULT])
    else $error("fault event not in status");
  st_load_a: assert property (CE && LP_LOAD |=> status_reg[IRQ_LP_UPDATE])
    else $error("ability load not in status");
  st_clr_a: assert property (CE && st_rd && !PAGE_RX_PULSE
    && !PD_FAULT_PULSE && !LP_LOAD |=> status_reg == IRQ_RESET)
    else $error("status not cleared by read");
  mask_wr_a: assert property (CE && wr_done && hit_mask |=>
    mask_reg == $past(PWDATA[IRQ_W-1:0]))
    else $error("mask write not applied");
  irq_level_a: assert property (CE |=>
    IRQ == $past(|(status_reg & mask_reg)))
    else $error("interrupt level wrong");

  // clock enable low freezes state
  freeze_a: assert property (!CE |=> $stable(cfg_reg)
    && $stable(status_reg) && $stable(lp_reg)
    && $stable(page_rx_reg) && $stable(pd_fault_reg))
    else $error("state changed while clock enable low");

  // scenarios
  exp_read_c: cover property (page_rx_reg && exp_rd ##1 !page_rx_reg);
  cfg_write_c: cover property (wr_done && hit_cfg);
  irq_rise_c: cover property ($rose(IRQ));
  unmapped_c: cover property (PREADY && PSLVERR);
  fault_clear_c: cover property (pd_fault_reg && exp_rd ##1 !pd_fault_reg);

endmodule // anreg_top
`default_nettype wire

// ==== verification/anreg_apb_mgmt.sv ====
// apb management master standing in for the mac-side controller
`timescale 1ns/1ps
`default_nettype none
module anreg_apb_mgmt (
  // clock and command
  input wire logic clk,
  input wire logic go,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  output logic done,
  output logic [31:0] rdata,
  output logic err,
  // apb master lines
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  // setup, access until pready, then release with inverted lines
  initial begin
    {psel, penable, pwrite, paddr, pwdata, done, rdata, err} = '0;
  end
  always @(posedge clk) begin
    done <= 1'h0;
    if (!psel && go) begin
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= (wr && addr == 8'h18) ? (wdata & 32'h1F) : wdata;
    end else if (!penable) begin
      penable <= psel;
    end else if (pready) begin
      {psel, penable} <= 2'h0;
      pwrite <= ~pwrite;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
      rdata <= prdata;
      err <= pslverr;
      done <= 1'h1;
    end
  end
endmodule // anreg_apb_mgmt
`default_nettype wire

// ==== verification/tb_phy_autoneg_status_config_regs.sv ====
// self-checking bench for the negotiation status and config registers
`timescale 1ns/1ps
`default_nettype none
module tb_phy_autoneg_status_config_regs;
  logic mclk, rst_n, go, wr, done, err, psel, pen, pwr, pready, pslverr;
  logic lp_load, page_rx, pd_fault, np_in, an_in, irq, strap_bc, strap_rp;
  logic sd_pin, ce;
  logic [7:0] addr, paddr;
  logic [31:0] wdata, rdata, pwdata, prdata;
  logic [8:0] lp_in;
  logic [6:0] dp;
  int n_mismatch = 0;
  int compares = 0;

  // clock
  always #2.5 mclk = ~mclk;

  anreg_apb_mgmt mgmt (.clk(mclk), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .done(done), .rdata(rdata), .err(err), .psel(psel),
    .penable(pen), .pwrite(pwr), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));

  anreg_top dut (.MCLK(mclk), .RESET_N(rst_n), .CE(ce), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LP_LOAD(lp_load),
    .LP_ABILITY_IN(lp_in), .PAGE_RX_PULSE(page_rx),
    .PD_FAULT_PULSE(pd_fault), .PARTNER_NP_IN(np_in),
    .PARTNER_AN_IN(an_in), .STRAP_BYPASS_CODING(strap_bc),
    .STRAP_REPEATER(strap_rp), .SIGNAL_DETECT_PIN(sd_pin),
    .BYPASS_CODING(dp[6]), .BYPASS_SCRAMBLE(dp[5]), .BYPASS_ALIGN(dp[4]),
    .FORCE_SD(dp[3]), .REPEATER_MODE(dp[2]), .TX_MODE(dp[1]),
    .SIGNAL_DETECT_OUT(dp[0]), .IRQ(irq));

  // compare, bus access and read-compare helpers
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
    int k;
    k = 0;
    wr <= w;
    addr <= a;
    wdata <= d;
    go <= 1'h1;
    @(posedge mclk) go <= 1'h0;
    do @(posedge mclk); while (done !== 1'h1 && ++k < 20);
    if (k >= 20) chk("bus answer", 32'h1, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, logic [31:0] e, input string nm);
    bus(1'h0, a, 32'h0);
    chk(nm, e, rdata);
  endtask
  task automatic wait_irq(input logic e);
    repeat (2) @(posedge mclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // reset values and strap capture
  task automatic t_defaults;
    rd(8'h40, 32'h8400, "config");
    chk("datapath", 32'h42, {25'h0, dp});
    rd(8'h14, 32'h0, "ability");
    rd(8'h18, 32'h0, "expansion");
  endtask

  // partner ability loads, read-only writes dropped
  task automatic t_partner;
    for (int i = 0; i < 2; i++) begin
      lp_in <= i ? 9'h05A : 9'h1A5;
      {np_in, an_in, lp_load} <= 3'h7;
      @(posedge mclk) lp_load <= 1'h0;
      bus(1'h1, 8'h14, i ? 32'h1A5 : 32'h05A);
      rd(8'h14, i ? 32'h05A : 32'h1A5, "ability");
    end
    bus(1'h1, 8'h18, 32'h1F);
    rd(8'h18, 32'h9, "expansion");
  endtask

  // latched page and fault bits clear on read
  task automatic t_latch;
    page_rx <= 1'h1;
    @(posedge mclk) page_rx <= 1'h0;
    pd_fault <= 1'h1;
    @(posedge mclk) pd_fault <= 1'h0;
    rd(8'h18, 32'h1B, "expansion set");
    rd(8'h18, 32'h09, "expansion cleared");
    ce <= 1'h0;
    page_rx <= 1'h1;
    @(posedge mclk) {ce, page_rx} <= 2'h2;
    rd(8'h18, 32'h09, "expansion frozen");
  endtask

  // each config bit alone drives its datapath control
  task automatic t_config;
    logic [5:0] e;
    for (int i = 0; i < 6; i++) begin
      e = 6'h1 << i;
      bus(1'h1, 8'h40, {16'h0, e, 10'h3FF});
      rd(8'h40, {16'h0, e, 10'h0}, "config");
      chk("datapath", {25'h0, e, e[2]}, {25'h0, dp});
    end
  endtask

  // status, mask, level interrupt and unmapped access
  task automatic t_irq;
    rd(8'h80, 32'h7, "status");
    rd(8'h80, 32'h0, "status cleared");
    bus(1'h1, 8'h84, 32'h1);
    rd(8'h84, 32'h1, "mask");
    pd_fault <= 1'h1;
    @(posedge mclk) pd_fault <= 1'h0;
    wait_irq(1'h0);
    page_rx <= 1'h1;
    @(posedge mclk) page_rx <= 1'h0;
    wait_irq(1'h1);
    rd(8'h80, 32'h3, "status");
    wait_irq(1'h0);
    rd(8'hFC, 32'h0, "unmapped data");
    chk("unmapped error", 32'h1, {31'h0, err});
    sd_pin <= 1'h1;
    repeat (4) @(posedge mclk);
    chk("signal detect", 32'h1, {31'h0, dp[0]});
    sd_pin <= 1'h0;
    repeat (4) @(posedge mclk);
    chk("signal detect", 32'h0, {31'h0, dp[0]});
  endtask

  // verdict
  task automatic report_and_stop;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // main sequence
  initial begin
    {mclk, rst_n, go, wr, addr, wdata, lp_load, lp_in} = '0;
    {page_rx, pd_fault, np_in, an_in, strap_rp, sd_pin} = '0;
    strap_bc = 1'h1;
    ce = 1'h1;
    repeat (16) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    t_defaults;
    t_partner;
    t_latch;
    t_config;
    t_irq;
    report_and_stop;
  end

  // watchdog
  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    report_and_stop;
  end
endmodule // tb_phy_autoneg_status_config_regs
`default_nettype wire
